// [hw/sss_pkg.sv]
// Package with register map, field positions and divider constants of the sound synthesizer.
package sss_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [3:0] REG_TONE_A_LOW = 4'h0;
   localparam logic [3:0] REG_TONE_A_HIGH = 4'h1;
   localparam logic [3:0] REG_NOISE_PERIOD = 4'h6;
   localparam logic [3:0] REG_MIXER_ENABLE = 4'h7;
   localparam logic [3:0] REG_AMP_A = 4'h8;
   localparam logic [3:0] REG_ENV_LOW = 4'hb;
   localparam logic [3:0] REG_ENV_HIGH = 4'hc;
   localparam logic [3:0] REG_ENV_SHAPE = 4'hd;
   localparam int NUM_REGS = 16;
   localparam int NUM_CHANNELS = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MIXER_RESET = 8'hff;
   // Address decode: word index field and top of the mapped range.
   localparam int ADDR_INDEX_LSB = 2;
   localparam logic [11:0] ADDR_LIMIT = 12'h040;
   // Field positions.
   localparam int TONE_HIGH_BITS = 4;
   localparam int NOISE_PERIOD_BITS = 5;
   localparam int NOISE_ENABLE_LSB = 3;
   localparam int AMP_MODE_BIT = 4;
   localparam int SHAPE_HOLD = 0;
   localparam int SHAPE_ALTERNATE = 1;
   localparam int SHAPE_ATTACK = 2;
   localparam int SHAPE_CONTINUE = 3;
   // Prescalers.
   localparam int TONE_PRESCALE = 16;
   localparam int ENV_PRESCALE = 256;
   localparam logic [7:0] TONE_PRE_LAST = 8'(TONE_PRESCALE - 1);
   localparam logic [7:0] ENV_PRE_LAST = 8'(ENV_PRESCALE - 1);
   localparam logic [16:0] NOISE_LFSR_SEED = 17'h00001;
   typedef enum logic [1:0] {SSS_ENV_RUN, SSS_ENV_HOLD} sss_env_e;
endpackage

// [hw/sss_core.sv]
// Three-channel sound synthesizer core with an APB register slave.
//
// Notes on behaviour
// - Sixteen byte registers control everything; sound runs on without further writes.
// - Three channels A, B and C, each controlled independently.
// - Tone: clock divided by 16, then by the 12-bit tone period, square wave.
// - Tone period: fine byte gives bits 7..0, coarse low nibble bits 11..8.
// - Indices 0-5 tone, 6 noise, 7 mixer, 8-10 amplitude, 11-13 envelope, 14-15 unused.
// - One shared noise generator giving a pseudo-random square wave.
// - Each channel mixes its tone output with the shared noise output.
// - Amplitude is either the fixed register level or the envelope level.
// - Each channel output is a level of sixteen values.
// - The envelope level can modulate any channel's mixer output.
// - Noise: clock divided by 16, then by the low five bits of register 6.
// - Register 7 bits 2..0 tone, 5..3 noise enables, active low.
// - Registers 8-10: bit 4 selects envelope, bits 3..0 fixed level.
// - Envelope step: clock divided by 256, then by 16-bit period of registers 12:11.
`timescale 1ns/10ps
module sss_core
   import sss_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel levels A, B, C.
   output logic [3:0] level_a,
   output logic [3:0] level_b,
   output logic [3:0] level_c
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] regs [NUM_REGS];
   logic apb_access;
   logic addr_ok;
   logic [3:0] addr_index;

   assign apb_access = psel && penable;
   assign addr_ok = (paddr < ADDR_LIMIT) && (paddr[1:0] == 2'b00);
   assign addr_index = paddr[ADDR_INDEX_LSB +: 4];

   // Zero-extended period from a low byte and a high byte masked to width.
   function automatic logic [15:0] period_of(input logic [7:0] lo, input logic [7:0] hi,
                                             input int hi_bits);
      logic [7:0] mask;
      mask = 8'((9'h001 << hi_bits) - 9'h001);
      period_of = {hi & mask, lo};
   endfunction

   // Up-counter divider step: true when the count has expired.
   function automatic logic expired(input logic [15:0] cnt, input logic [15:0] period);
      expired = (cnt + 16'h0001 >= period);
   endfunction

   // A write lands in the first access cycle, at the same edge that raises pready.
   // Only the low byte of the write data is kept; the upper bits are dropped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs[i] <= REG_RESET;
         end
         regs[REG_MIXER_ENABLE] <= MIXER_RESET;
      end
      else if (apb_access && pwrite && addr_ok && !pready)
      begin
         regs[addr_index] <= pwdata[7:0];
      end
   end

   // One wait state: pready rises in the first access cycle, then drops.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (apb_access && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !addr_ok;
         if (!pwrite && addr_ok)
         begin
            prdata <= {24'h000000, regs[addr_index]};
         end
         else
         begin
            prdata <= 32'h00000000;
         end
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescalers shared by all generators.

   // One free-running counter serves both prescalers, so the tone and noise ticks
   // stay in step with the envelope tick.
   logic [7:0] pre_cnt;
   logic tone_tick;
   logic env_tick;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt <= 8'h00;
      end
      else
      begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   assign tone_tick = (pre_cnt[3:0] == TONE_PRE_LAST[3:0]);
   assign env_tick = (pre_cnt == ENV_PRE_LAST);

   ////////////////////////////////////////////////////////////////////////////////
   // Tone generators.

   // A period of zero behaves like one: the counter expires on every tick.
   logic [11:0] tone_cnt [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] tone_out;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
         begin
            tone_cnt[c] <= 12'h000;
            tone_out[c] <= 1'b0;
         end
      end
      else if (tone_tick)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
         begin
            // Fine at even index, coarse at the next odd one.
            if (expired({4'h0, tone_cnt[c]},
                        period_of(regs[2*c], regs[2*c+1], TONE_HIGH_BITS)))
            begin
               tone_cnt[c] <= 12'h000;
               tone_out[c] <= !tone_out[c];
            end
            else
            begin
               tone_cnt[c] <= tone_cnt[c] + 12'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Noise generator.

   // The shift register gives a long pseudo-random bit sequence; its output bit is
   // sampled once per noise period, so runs of equal bits widen the pulses.
   logic [4:0] noise_cnt;
   logic [16:0] lfsr;
   logic noise_out;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         noise_cnt <= 5'h00;
         lfsr <= NOISE_LFSR_SEED;
         noise_out <= 1'b0;
      end
      else if (tone_tick)
      begin
         if (expired({11'h000, noise_cnt},
                     period_of(regs[REG_NOISE_PERIOD], 8'h00, 0) &
                     16'h001f))
         begin
            noise_cnt <= 5'h00;
            lfsr <= {lfsr[0] ^ lfsr[3], lfsr[16:1]};
            noise_out <= lfsr[0];
         end
         else
         begin
            noise_cnt <= noise_cnt + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Envelope generator.

   logic [15:0] env_cnt;
   logic [3:0] env_step;
   logic env_flip;
   logic env_shape_wr;
   sss_env_e env_state;
   logic [3:0] env_level;
   logic [7:0] shape;

   // A shape write takes priority over a pending step, so the new pattern always
   // starts from step zero.
   assign shape = regs[REG_ENV_SHAPE];
   assign env_shape_wr = apb_access && pwrite && addr_ok && !pready &&
                         (addr_index == REG_ENV_SHAPE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         env_cnt <= 16'h0000;
         env_step <= 4'h0;
         env_flip <= 1'b0;
         env_state <= SSS_ENV_RUN;
      end
      else if (env_shape_wr)
      begin
         // Writing the shape restarts the envelope cycle.
         env_cnt <= 16'h0000;
         env_step <= 4'h0;
         env_flip <= 1'b0;
         env_state <= SSS_ENV_RUN;
      end
      else if (env_tick)
      begin
         if (expired(env_cnt, {regs[REG_ENV_HIGH], regs[REG_ENV_LOW]}))
         begin
            env_cnt <= 16'h0000;
            case (env_state)
               SSS_ENV_RUN:
               begin
                  env_step <= env_step + 4'h1;
                  if (env_step == 4'hf)
                  begin
                     if (!shape[SHAPE_CONTINUE] || shape[SHAPE_HOLD])
                     begin
                        env_state <= SSS_ENV_HOLD;
                        env_flip <= shape[SHAPE_CONTINUE] &&
                                    (shape[SHAPE_ALTERNATE] ^ env_flip);
                     end
                     else if (shape[SHAPE_ALTERNATE])
                     begin
                        env_flip <= !env_flip;
                     end
                  end
               end
               default:
               begin
                  env_step <= 4'hf;
               end
            endcase
         end
         else
         begin
            env_cnt <= env_cnt + 16'h0001;
         end
      end
   end

   // Level follows the step, inverted for decay, pinned while holding.
   always_comb
   begin
      logic up;
      up = shape[SHAPE_ATTACK] ^ env_flip;
      if (env_state == SSS_ENV_HOLD)
      begin
         env_level = (shape[SHAPE_CONTINUE] && up) ? 4'hf : 4'h0;
      end
      else
      begin
         env_level = up ? env_step : ~env_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mixers and amplitude control.

   logic [3:0] next_level [NUM_CHANNELS];

   always_comb
   begin
      logic [7:0] mix;
      logic [7:0] amp;
      logic gate;
      // Defaults keep the temporaries defined before the channel loop runs.
      amp = 8'h00;
      gate = 1'b0;
      mix = regs[REG_MIXER_ENABLE];
      for (int c = 0; c < NUM_CHANNELS; c++)
      begin
         amp = regs[int'(REG_AMP_A) + c];
         // Disabled sources read as high so they do not gate the other one.
         gate = (tone_out[c] | mix[c]) &
                (noise_out | mix[NOISE_ENABLE_LSB + c]);
         if (!gate)
         begin
            next_level[c] = 4'h0;
         end
         else if (amp[AMP_MODE_BIT])
         begin
            next_level[c] = env_level;
         end
         else
         begin
            next_level[c] = amp[3:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         level_a <= 4'h0;
         level_b <= 4'h0;
         level_c <= 4'h0;
      end
      else
      begin
         level_a <= next_level[0];
         level_b <= next_level[1];
         level_c <= next_level[2];
      end
   end

endmodule // sss_core

// [tb/sss_core_sva.sv]
// Assertions on the register bus ports of the synthesizer core.
`timescale 1ns/10ps
module sss_core_sva (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Channel levels.
   input wire logic [3:0] level_a,
   input wire logic [3:0] level_b,
   input wire logic [3:0] level_c
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic take;
   assign take = psel && penable && !pready;
   a_ready_one_wait: assert property (take |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_ready_cause: assert property (pready |-> $past(take))
      else $error("pready without access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_err_unmapped: assert property (take && paddr >= 12'h040 |=> pslverr)
      else $error("no pslverr");
   a_err_mapped: assert property (take && paddr < 12'h040 && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("false pslverr");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("prdata upper bits set");
   a_bad_read_zero: assert property (take && !pwrite && paddr >= 12'h040 |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (take && pwrite);
   cover property (take && paddr >= 12'h040);
   cover property ($changed(level_a));
endmodule // sss_core_sva

bind sss_core sss_core_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .level_a(level_a), .level_b(level_b), .level_c(level_c));

// [tb/sss_proc.sv]
// Control processor model that loads the synthesizer registers over APB.
`timescale 1ns/10ps
module sss_proc (
   // Clock.
   input wire logic pclk,
   // APB master side.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // The request is held until pready is seen at a rising edge.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // sss_proc

// [tb/test_three_channel_sound_synth.sv]
// Self-checking testbench for the sound synthesizer core.
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_three_channel_sound_synth
   import sss_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] level_a, level_b, level_c, v0, v1;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   sss_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .level_a(level_a), .level_b(level_b), .level_c(level_c));
   sss_proc proc (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      proc.xfer(1'b1, {6'h00, i, 2'b00}, d, q, e);
      `CHK(e, 1'b0)
   endtask
   function automatic logic [3:0] lvl(input int ch);
      if (ch == 0)
         lvl = level_a;
      else if (ch == 1)
         lvl = level_b;
      else
         lvl = level_c;
   endfunction
   // Counts clocks between the second and third change of one channel.
   // The first change may come from the last register write, so it only synchronises.
   task automatic gap(input int ch);
      for (int k = 0; k < 3; k++)
      begin
         v0 = lvl(ch);
         n = 0;
         while (lvl(ch) === v0 && n < 5000)
         begin
            @(negedge pclk);
            n++;
         end
      end
      v1 = lvl(ch);
   endtask
   task automatic t_reset();
      for (int i = 0; i < NUM_REGS; i++)
      begin
         proc.xfer(1'b0, 12'(i * 4), 32'h0, q, e);
         `CHK(q, (i == 7) ? {24'h0, MIXER_RESET} : 32'h0)
      end
   endtask
   task automatic t_regs();
      wr(REG_TONE_A_HIGH, 32'h123456a5);
      proc.xfer(1'b0, 12'h004, 32'h0, q, e);
      `CHK(q, 32'h000000a5)
      proc.xfer(1'b1, 12'h040, 32'h5a, q, e);
      `CHK(e, 1'b1)
      proc.xfer(1'b0, 12'h040, 32'h0, q, e);
      `CHK({e, q}, 33'h100000000)
   endtask
   task automatic t_fixed();
      wr(REG_MIXER_ENABLE, 32'hff);
      wr(REG_AMP_A, 32'h0a);
      wr(4'h9, 32'he5);
      wr(4'ha, 32'he7);
      repeat (3) @(posedge pclk);
      `CHK(level_a, 4'ha)
      `CHK(level_b, 4'h5)
      `CHK(level_c, 4'h7)
   endtask
   task automatic t_tone();
      wr(REG_TONE_A_LOW, 32'h02);
      wr(REG_TONE_A_HIGH, 32'hf0);
      wr(4'h4, 32'h00);
      wr(4'h5, 32'hf1);
      wr(REG_AMP_A, 32'h0f);
      wr(4'ha, 32'h0f);
      wr(REG_MIXER_ENABLE, 32'h3a);
      gap(0);
      `CHK(n, 32)
      `CHK(v0 ^ v1, 4'hf)
      gap(2);
      `CHK(n, 4096)
      `CHK(v0 ^ v1, 4'hf)
   endtask
   task automatic t_noise();
      wr(REG_NOISE_PERIOD, 32'he3);
      wr(REG_MIXER_ENABLE, 32'h37);
      gap(0);
      `CHK(n % 48, 0)
      `CHK(v0 ^ v1, 4'hf)
   endtask
   task automatic t_env();
      wr(REG_MIXER_ENABLE, 32'hff);
      wr(REG_ENV_LOW, 32'h01);
      wr(REG_ENV_HIGH, 32'h00);
      wr(REG_AMP_A, 32'h10);
      wr(REG_ENV_SHAPE, 32'h0c);
      gap(0);
      `CHK(n, 256)
      `CHK(v1, 4'(v0 + 4'h1))
   endtask
   task automatic test_done();
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         test_done();
      end
   end
   initial
   begin
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_fixed();
      t_tone();
      t_noise();
      t_env();
      test_done();
   end
endmodule // test_three_channel_sound_synth
